// ==== atc_pkg.sv ====
// shared types and constants of the actuator teach-in controller
package atc_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_CLR  = 8'h0C;
   localparam logic [7:0] REG_IRQ_EN   = 8'h10;
   localparam logic [7:0] REG_CODE     = 8'h14;
   localparam int         CTRL_UNIV_BIT = 0;  // universally coded variant
   localparam int         CTRL_POL_BIT  = 1;  // 1: power to lock
   localparam logic [1:0] CTRL_RST      = 2'h2;
   localparam int         EV_TAUGHT = 0;
   localparam int         EV_SAFE   = 1;
   localparam int         EV_RUN    = 2;
   localparam int         EV_W      = 3;
   localparam int         CODE_W    = 16;
   localparam int         DEACT_N   = 3;

   // ---------------------------------------------------------------
   // timing: one prescaled millisecond tick drives every timer
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIRST_WIN_MIN = 30;
   localparam int FIRST_WIN_MS  = FIRST_WIN_MIN * 60000;
   localparam int REPL_WIN_MIN  = 5;
   localparam int REPL_WIN_MS   = REPL_WIN_MIN * 60000;
   localparam int CONFIRM_MIN   = 5;
   localparam int CONFIRM_MS    = CONFIRM_MIN * 60000;
   localparam int LOCK_TO_MIN   = 10;
   localparam int LOCK_TO_MS    = LOCK_TO_MIN * 60000;
   localparam int DWELL_S       = 3;
   localparam int DWELL_MS      = DWELL_S * 1000;
   localparam int START_MS      = 2000;
   localparam int LEARN_MS      = 1000;
   localparam int BLINK1_HALF_MS = 500;   // 1 Hz
   localparam int BLINK2_HALF_MS = 250;   // 2 Hz
   localparam int BLINK4_HALF_MS = 125;   // 4 Hz

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {COL_OFF, COL_RED, COL_GREEN, COL_YELLOW}
      atc_col_t;
   typedef enum logic [2:0] {CAUSE_NONE, CAUSE_WINDOW, CAUSE_CONFIRM,
      CAUSE_REMOVED, CAUSE_SUPPLY, CAUSE_DEACT, CAUSE_LOCK} atc_cause_t;
   typedef enum logic [3:0] {S_LOAD, S_START, S_WAIT_FIRST, S_WAIT_REPL,
      S_DWELL, S_LEARN, S_DONE, S_RUN, S_SAFE} atc_state_t;

   typedef struct packed {
      logic              present;
      logic              in_pos;
      logic [CODE_W-1:0] code;
   } atc_act_t;

   typedef struct packed {
      atc_col_t state;
      atc_col_t lock;
      atc_col_t diag;
   } atc_ind_t;

   typedef struct packed {
      logic                            taught;
      logic                            pend;
      logic                            busy;
      logic [CODE_W-1:0]               code;
      logic [CODE_W-1:0]               pcode;
      logic [DEACT_N-1:0]              deact_v;
      logic [DEACT_N-1:0][CODE_W-1:0]  deact;
   } atc_nv_t;

   typedef struct packed {
      atc_state_t        st;
      atc_cause_t        cause;
      logic              repl;
      logic [31:0]       pre;
      logic              tick;
      logic [31:0]       tmr;
      logic [31:0]       aux;
      logic [31:0]       lck;
      logic [15:0]       blk;
      atc_nv_t           nv;
      logic              nv_stb;
      logic [1:0]        ctrl;
      logic [EV_W-1:0]   irq_stat;
      logic [EV_W-1:0]   irq_en;
      logic              a_wr;
      logic [7:0]        a_addr;
      logic [31:0]       rdata;
      logic              ch_a;
      logic              ch_b;
      logic              lock_drv;
      atc_ind_t          ind;
   } atc_regs_t;

endpackage

// ==== atc_ctrl.sv ====
// actuator teach-in controller with ahb-lite register slave
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module atc_ctrl #(
   parameter int TICK_CYC      = atc_pkg::TICK_CYC,
   parameter int FIRST_WIN_MS  = atc_pkg::FIRST_WIN_MS,
   parameter int REPL_WIN_MS   = atc_pkg::REPL_WIN_MS,
   parameter int CONFIRM_MS    = atc_pkg::CONFIRM_MS,
   parameter int LOCK_TO_MS    = atc_pkg::LOCK_TO_MS,
   parameter int DWELL_MS      = atc_pkg::DWELL_MS,
   parameter int START_MS      = atc_pkg::START_MS,
   parameter int LEARN_MS      = atc_pkg::LEARN_MS
) (
   input  wire logic              hclk,                    // bus clock
   input  wire logic              hresetn,                 // power-up reset
   input  wire logic              hsel,                    // slave select
   input  wire logic [31:0]       haddr,                   // byte address
   input  wire logic [1:0]        htrans,                  // transfer type
   input  wire logic              hwrite,                  // write access
   input  wire logic [2:0]        hsize,                   // word only
   input  wire logic [31:0]       hwdata,                  // write data
   input  wire logic              hready,                  // bus ready
   output logic      [31:0]       hrdata,                  // read data
   output logic                   hreadyout,               // never waits
   output logic                   hresp,                   // always okay
   input  wire atc_pkg::atc_act_t act,                     // actuator sense
   input  wire logic              lock_cmd,                // lock input pin
   input  wire logic              lock_engaged,            // bolt locked
   input  wire logic              enable_in_a,             // enable chan a
   input  wire logic              enable_in_b,             // enable chan b
   input  wire atc_pkg::atc_nv_t  nv_rd,                   // stored codes
   output logic                   nv_wr_stb,               // store pulse
   output atc_pkg::atc_nv_t       nv_wr,                   // data to store
   output logic                   lock_drive,              // lock actuator
   output logic                   safety_output_channel_a, // channel a
   output logic                   safety_output_channel_b, // channel b
   output atc_pkg::atc_ind_t      ind,                     // indicators
   output logic                   irq                      // interrupt
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // code among the remembered deactivated codes
   function automatic logic is_deact(input atc_pkg::atc_nv_t nv,
                                     input logic [atc_pkg::CODE_W-1:0] c);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < atc_pkg::DEACT_N; i++) begin
         if (nv.deact_v[i] && nv.deact[i] == c) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // timer reached a millisecond limit
   function automatic logic at_ms(input logic [31:0] t, input int lim);
      return t >= 32'(lim);
   endfunction

   atc_pkg::atc_regs_t r;
   atc_pkg::atc_regs_t n;
   logic               b1;
   logic               b2;
   logic               b4;
   logic               univ;
   logic               lock_req;
   logic               act_valid;
   logic               a_take;

   // blink phases from the millisecond counter
   assign b1 = r.blk < 16'(atc_pkg::BLINK1_HALF_MS);
   assign b2 = (r.blk % 16'(2 * atc_pkg::BLINK2_HALF_MS))
               < 16'(atc_pkg::BLINK2_HALF_MS);
   assign b4 = (r.blk % 16'(2 * atc_pkg::BLINK4_HALF_MS))
               < 16'(atc_pkg::BLINK4_HALF_MS);
   assign univ = r.ctrl[atc_pkg::CTRL_UNIV_BIT];
   // lock request level follows variant polarity
   assign lock_req = r.ctrl[atc_pkg::CTRL_POL_BIT] ? lock_cmd
                                                   : !lock_cmd;
   // only the latest taught code counts, or any for universal
   assign act_valid = act.present &&
                      (univ || (r.nv.taught && act.code == r.nv.code));
   assign a_take = hsel && hready && htrans[1];

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      n = r;
      n.nv_stb = 1'b0;
      // one prescaled tick feeds all timers
      n.tick = 1'b0;
      if (r.pre >= 32'(TICK_CYC - 1)) begin
         n.pre = '0;
         n.tick = 1'b1;
      end else begin
         n.pre = r.pre + 32'h1;
      end
      if (r.tick) begin
         n.tmr = r.tmr + 32'h1;
         n.aux = r.aux + 32'h1;
         n.blk = (r.blk >= 16'(2 * atc_pkg::BLINK1_HALF_MS - 1)) ? 16'h0
                 : r.blk + 16'h1;
      end

      // bus: address phase capture and data phase write
      n.a_wr = a_take && hwrite;
      n.a_addr = haddr[7:0];
      if (a_take && !hwrite) begin
         case (haddr[7:0])
            atc_pkg::REG_CTRL:     n.rdata = {30'h0, r.ctrl};
            atc_pkg::REG_STATUS:   n.rdata = {20'h0, 1'b0, r.cause,
               r.st, r.lock_drv, r.nv.taught, r.ch_b, r.ch_a};
            atc_pkg::REG_IRQ_STAT: n.rdata = {29'h0, r.irq_stat};
            atc_pkg::REG_IRQ_EN:   n.rdata = {29'h0, r.irq_en};
            atc_pkg::REG_CODE:     n.rdata = {16'h0, r.nv.code};
            default:               n.rdata = 32'h0;
         endcase
      end
      if (r.a_wr) begin
         case (r.a_addr)
            atc_pkg::REG_CTRL:    n.ctrl = hwdata[1:0];
            atc_pkg::REG_IRQ_CLR: n.irq_stat = r.irq_stat & ~hwdata[2:0];
            atc_pkg::REG_IRQ_EN:  n.irq_en = hwdata[2:0];
            default:              n.ctrl = n.ctrl;
         endcase
      end

      // teach-in sequencing
      case (r.st)
         atc_pkg::S_LOAD: begin
            n.nv = nv_rd;
            n.aux = '0;
            n.st = atc_pkg::S_START;
            if (nv_rd.busy) begin
               // supply lost while learning: teach-in invalid
               n.nv.busy = 1'b0;
               n.nv_stb = 1'b1;
               n.st = atc_pkg::S_SAFE;
               n.cause = atc_pkg::CAUSE_SUPPLY;
            end else if (nv_rd.pend) begin
               // restart confirms the new code, old one retired
               n.nv.pend = 1'b0;
               n.nv.taught = 1'b1;
               n.nv.code = nv_rd.pcode;
               if (nv_rd.taught) begin
                  n.nv.deact = {nv_rd.deact[1:0], nv_rd.code};
                  n.nv.deact_v = {nv_rd.deact_v[1:0], 1'b1};
               end
               n.nv_stb = 1'b1;
            end
         end
         atc_pkg::S_START: begin
            // self test holds outputs off
            if (at_ms(r.aux, START_MS)) begin
               n.tmr = '0;
               if (univ) begin
                  n.st = atc_pkg::S_RUN;
               end else if (!r.nv.taught) begin
                  n.st = atc_pkg::S_WAIT_FIRST;
                  n.repl = 1'b0;
               end else begin
                  n.st = atc_pkg::S_WAIT_REPL;
                  n.repl = 1'b1;
               end
            end
         end
         atc_pkg::S_WAIT_FIRST: begin
            if (at_ms(r.tmr, FIRST_WIN_MS)) begin
               n.st = atc_pkg::S_SAFE;
               n.cause = atc_pkg::CAUSE_WINDOW;
            end else if (act.present && act.in_pos) begin
               n.st = atc_pkg::S_DWELL;
               n.aux = '0;
            end
         end
         atc_pkg::S_WAIT_REPL: begin
            if (at_ms(r.tmr, REPL_WIN_MS)) begin
               n.st = atc_pkg::S_RUN;
            end else if (act.present && act.code == r.nv.code) begin
               n.st = atc_pkg::S_RUN;
            end else if (act.present && is_deact(r.nv, act.code)) begin
               n.st = atc_pkg::S_SAFE;
               n.cause = atc_pkg::CAUSE_DEACT;
            end else if (act.present && act.in_pos) begin
               n.st = atc_pkg::S_DWELL;
               n.aux = '0;
            end
         end
         atc_pkg::S_DWELL: begin
            // actuator must stay in position before learning
            if (!(act.present && act.in_pos)) begin
               n.st = r.repl ? atc_pkg::S_WAIT_REPL
                             : atc_pkg::S_WAIT_FIRST;
            end else if (r.repl && is_deact(r.nv, act.code)) begin
               n.st = atc_pkg::S_SAFE;
               n.cause = atc_pkg::CAUSE_DEACT;
            end else if (at_ms(r.aux, DWELL_MS)) begin
               n.st = atc_pkg::S_LEARN;
               n.aux = '0;
               n.nv.busy = 1'b1;
               n.nv.pcode = act.code;
               n.nv_stb = 1'b1;
            end
         end
         atc_pkg::S_LEARN: begin
            if (!act.present || act.code != r.nv.pcode) begin
               n.st = atc_pkg::S_SAFE;
               n.cause = atc_pkg::CAUSE_REMOVED;
               n.nv.busy = 1'b0;
               n.nv_stb = 1'b1;
            end else if (at_ms(r.aux, LEARN_MS)) begin
               n.st = atc_pkg::S_DONE;
               n.tmr = '0;
               n.nv.busy = 1'b0;
               n.nv.pend = 1'b1;
               n.nv_stb = 1'b1;
               n.irq_stat[atc_pkg::EV_TAUGHT] = 1'b1;
            end
         end
         atc_pkg::S_DONE: begin
            // restart must follow; otherwise drop the new code
            if (at_ms(r.tmr, CONFIRM_MS)) begin
               n.st = atc_pkg::S_SAFE;
               n.cause = atc_pkg::CAUSE_CONFIRM;
               n.nv.pend = 1'b0;
               n.nv_stb = 1'b1;
            end
         end
         atc_pkg::S_RUN: begin
            // retry locking while a valid actuator is present
            if (act_valid && lock_req && !lock_engaged) begin
               if (r.tick) begin
                  n.lck = r.lck + 32'h1;
               end
               if (at_ms(r.lck, LOCK_TO_MS)) begin
                  n.st = atc_pkg::S_SAFE;
                  n.cause = atc_pkg::CAUSE_LOCK;
               end
            end else begin
               n.lck = '0;
            end
         end
         atc_pkg::S_SAFE: n.st = atc_pkg::S_SAFE;
         default: n.st = atc_pkg::S_SAFE;
      endcase

      // events, set wins over clear
      if (n.st == atc_pkg::S_SAFE && r.st != atc_pkg::S_SAFE) begin
         n.irq_stat[atc_pkg::EV_SAFE] = 1'b1;
      end
      if (n.st == atc_pkg::S_RUN && r.st != atc_pkg::S_RUN) begin
         n.irq_stat[atc_pkg::EV_RUN] = 1'b1;
      end

      // outputs follow the next state so they match it
      n.lock_drv = (n.st == atc_pkg::S_RUN) && act_valid && lock_req;
      n.ch_a = (n.st == atc_pkg::S_RUN) && act_valid && enable_in_a;
      n.ch_b = (n.st == atc_pkg::S_RUN) && act_valid && enable_in_b;

      // indicator patterns
      n.ind.state = atc_pkg::COL_RED;
      n.ind.lock = atc_pkg::COL_OFF;
      n.ind.diag = b4 ? atc_pkg::COL_YELLOW : atc_pkg::COL_RED;
      case (n.st)
         atc_pkg::S_LOAD, atc_pkg::S_START: begin
            n.ind.state = b2 ? atc_pkg::COL_RED : atc_pkg::COL_GREEN;
            n.ind.lock = b2 ? atc_pkg::COL_OFF : atc_pkg::COL_GREEN;
            n.ind.diag = b2 ? atc_pkg::COL_RED : atc_pkg::COL_YELLOW;
         end
         atc_pkg::S_WAIT_FIRST, atc_pkg::S_WAIT_REPL,
         atc_pkg::S_DWELL: begin
            n.ind.state = atc_pkg::COL_RED;
         end
         atc_pkg::S_LEARN: begin
            n.ind.state = b4 ? atc_pkg::COL_GREEN : atc_pkg::COL_OFF;
         end
         atc_pkg::S_DONE: begin
            n.ind.state = b4 ? atc_pkg::COL_GREEN : atc_pkg::COL_OFF;
            n.ind.diag = b4 ? atc_pkg::COL_YELLOW : atc_pkg::COL_OFF;
         end
         atc_pkg::S_SAFE: begin
            // diag blinks only for a missed restart confirm, steady red for other causes
            n.ind.state = b4 ? atc_pkg::COL_RED : atc_pkg::COL_GREEN;
            n.ind.diag = (n.cause == atc_pkg::CAUSE_CONFIRM) ?
               (b4 ? atc_pkg::COL_RED : atc_pkg::COL_OFF) : atc_pkg::COL_RED;
         end
         atc_pkg::S_RUN: begin
            n.ind.state = (n.ch_a && n.ch_b) ? atc_pkg::COL_GREEN
               : act_valid ? (b1 ? atc_pkg::COL_GREEN : atc_pkg::COL_OFF)
               : atc_pkg::COL_RED;
            n.ind.lock = !lock_req ? atc_pkg::COL_OFF
               : (act_valid && lock_engaged) ? atc_pkg::COL_GREEN
               : (b1 ? atc_pkg::COL_GREEN : atc_pkg::COL_OFF);
            n.ind.diag = (enable_in_a && enable_in_b) ? atc_pkg::COL_OFF
                                                      : atc_pkg::COL_YELLOW;
         end
         default: n.ind.state = atc_pkg::COL_RED;
      endcase
   end

   // ---------------------------------------------------------------
   // state register, all timers cleared at power-up
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.st <= atc_pkg::S_LOAD;
         r.ctrl <= atc_pkg::CTRL_RST;
         r.ind <= '0;
      end else begin
         r <= n;
      end
   end

   // port drive
   assign hrdata = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign nv_wr_stb = r.nv_stb;
   assign nv_wr = r.nv;
   assign lock_drive = r.lock_drv;
   assign safety_output_channel_a = r.ch_a;
   assign safety_output_channel_b = r.ch_b;
   assign ind = r.ind;
   assign irq = |(r.irq_stat & r.irq_en);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_learn_end;
      r.st == atc_pkg::S_LEARN && act.present
      && act.code == r.nv.pcode && at_ms(r.aux, LEARN_MS);
   endsequence
   sequence s_pend_stored;
      r.st == atc_pkg::S_DONE && r.nv_stb && r.nv.pend;
   endsequence

   a_start_outputs_off: assert property (
      r.st == atc_pkg::S_START |-> !r.ch_a && !r.ch_b)
      else $error("outputs on during start sequence");
   a_safe_holds: assert property (
      r.st == atc_pkg::S_SAFE |=> r.st == atc_pkg::S_SAFE && !r.ch_a
      && !r.ch_b)
      else $error("left safe state without restart");
   a_first_window: assert property (
      r.st == atc_pkg::S_WAIT_FIRST && at_ms(r.tmr, FIRST_WIN_MS)
      |=> r.st == atc_pkg::S_SAFE && r.cause == atc_pkg::CAUSE_WINDOW)
      else $error("first teach window did not expire to safe");
   a_learn_removed: assert property (
      r.st == atc_pkg::S_LEARN && !act.present
      |=> r.st == atc_pkg::S_SAFE && r.cause == atc_pkg::CAUSE_REMOVED)
      else $error("early removal not treated as abort");
   a_learn_commit: assert property (
      s_learn_end |=> s_pend_stored)
      else $error("successful teach did not store pending code");
   a_deact_safe: assert property (
      r.st == atc_pkg::S_WAIT_REPL && !at_ms(r.tmr, REPL_WIN_MS)
      && act.present && act.code != r.nv.code && is_deact(r.nv, act.code)
      |=> r.st == atc_pkg::S_SAFE && $stable(r.nv.code))
      else $error("deactivated actuator not rejected");
   a_valid_only: assert property (
      r.ch_a |-> $past(act.present) && ($past(univ)
      || $past(act.code) == r.nv.code))
      else $error("output on without the latest code");
   a_channel_indep: assert property (
      r.ch_b |-> $past(enable_in_b) && r.st == atc_pkg::S_RUN)
      else $error("channel b on without its enable");
   a_lock_timeout: assert property (
      r.st == atc_pkg::S_RUN && act_valid && lock_req && !lock_engaged
      && at_ms(r.lck, LOCK_TO_MS)
      |=> r.st == atc_pkg::S_SAFE && r.cause == atc_pkg::CAUSE_LOCK)
      else $error("lock retry timeout missed");

endmodule

// ==== atc_relay_model.sv ====
// partner model: safety controller and non-volatile code store
`timescale 1ns/1ps
module atc_relay_model (
   input  wire logic             hclk,         // system clock
   input  wire logic             lock_req,     // controller wants lock
   input  wire logic             pol_lock,     // 1: power to lock variant
   input  wire logic             bolt_ok,      // bolt free to engage
   input  wire logic             lock_drive,   // device drives solenoid
   input  wire logic             nv_wr_stb,    // store pulse
   input  wire atc_pkg::atc_nv_t nv_wr,        // image to store
   output logic                  lock_cmd,     // lock input pin
   output logic                  lock_engaged, // bolt locked
   output atc_pkg::atc_nv_t      nv_rd         // stored image
);
   // lock command level follows the variant polarity
   assign lock_cmd = pol_lock ? lock_req : ~lock_req;
   // bolt engages only when free and driven
   assign lock_engaged = bolt_ok & lock_drive;
   // store survives device resets like real non-volatile memory
   atc_pkg::atc_nv_t mem = '0;
   always @(posedge hclk) begin
      if (nv_wr_stb) begin
         mem <= nv_wr;
      end
   end
   assign nv_rd = mem;
endmodule

// ==== actuator_teach_in_controller_tb_top.sv ====
// self-checking testbench of the actuator teach-in controller
`timescale 1ns/1ps
module actuator_teach_in_controller_tb_top;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy, hresp, irq;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic pol = 1'b1; // model variant, follows the ctrl polarity bit
   // shortened timing so every window fits the run
   localparam int TB_TICK  = 4;
   localparam int TB_WIN   = 20;
   localparam int TB_DWELL = 3;
   localparam int TB_STEP  = 2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic lock_req = 0, bolt_ok = 0, en_a = 0, en_b = 0, lock_cmd, lk_eng;
   logic nv_stb, lock_drive, ch_a, ch_b;
   atc_pkg::atc_act_t act = '0;
   atc_pkg::atc_nv_t  nv_rd, nv_wr;
   atc_pkg::atc_ind_t ind;
   int err_count = 0, num_checks = 0;
   always #2 hclk = ~hclk;
   atc_ctrl #(.TICK_CYC(TB_TICK), .FIRST_WIN_MS(TB_WIN),
      .REPL_WIN_MS(TB_WIN), .CONFIRM_MS(TB_WIN), .LOCK_TO_MS(TB_WIN),
      .DWELL_MS(TB_DWELL), .START_MS(TB_STEP), .LEARN_MS(TB_STEP))
      i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
      .hresp(hresp), .act(act), .lock_cmd(lock_cmd),
      .lock_engaged(lk_eng), .enable_in_a(en_a), .enable_in_b(en_b),
      .nv_rd(nv_rd), .nv_wr_stb(nv_stb), .nv_wr(nv_wr),
      .lock_drive(lock_drive), .safety_output_channel_a(ch_a),
      .safety_output_channel_b(ch_b), .ind(ind), .irq(irq));
   atc_relay_model i_relay (.hclk(hclk), .lock_req(lock_req),
      .pol_lock(pol), .bolt_ok(bolt_ok), .lock_drive(lock_drive),
      .nv_wr_stb(nv_stb), .nv_wr(nv_wr), .lock_cmd(lock_cmd),
      .lock_engaged(lk_eng), .nv_rd(nv_rd));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h", $time, m, got);
      end
   endtask
   // one ahb-lite single transfer, held until hready is sampled
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hrdy !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      @(posedge hclk);
      while (hrdy !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // poll the status state field until it shows s, bounded
   task wait_st(input logic [3:0] s);
      int n;
      for (n = 0; n < 300; n++) begin
         bus(1'b0, atc_pkg::REG_STATUS, 32'h0);
         if (rd[7:4] === s) break;
      end
      chk({28'h0, rd[7:4]}, {28'h0, s}, "state");
   endtask
   task rst();
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   task clk(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      rst();
      bus(1'b0, atc_pkg::REG_CTRL, 32'h0);
      chk(rd, 32'h2, "ctrl reset");
      chk({ch_a, ch_b}, 32'h0, "outputs in start");
      wait_st(4'h2);
      chk({30'h0, ind.state}, {30'h0, atc_pkg::COL_RED}, "ready");
      chk({30'h0, ind.lock}, 32'h0, "lock dark");
      wait_st(4'h8);
      chk({29'h0, rd[10:8]}, 32'h1, "window cause");
      act <= '{1'b1, 1'b1, 16'hA5A5};
      clk(40);
      wait_st(4'h8);
      $display("test window done");
      act <= '0;
      rst();
      wait_st(4'h2);
      bus(1'b1, atc_pkg::REG_IRQ_EN, 32'h1);
      act <= '{1'b1, 1'b1, 16'hA5A5};
      wait_st(4'h4);
      wait_st(4'h5);
      chk({30'h0, ind.lock}, 32'h0, "learn lock dark");
      wait_st(4'h6);
      chk(irq, 32'h1, "irq taught");
      bus(1'b1, atc_pkg::REG_IRQ_CLR, 32'h1);
      clk(2);
      chk(irq, 32'h0, "irq cleared");
      $display("test teach done");
      rst();
      wait_st(4'h7);
      bus(1'b0, atc_pkg::REG_CODE, 32'h0);
      chk(rd, 32'h0000A5A5, "code");
      en_a <= 1'b1;
      clk(4);
      chk({ch_a, ch_b}, 32'h2, "chan a only");
      en_b <= 1'b1;
      clk(4);
      chk({ch_a, ch_b}, 32'h3, "both on");
      chk({30'h0, ind.state}, {30'h0, atc_pkg::COL_GREEN}, "green");
      lock_req <= 1'b1;
      clk(2);
      chk(lock_drive, 32'h1, "lock drive");
      bus(1'b1, atc_pkg::REG_CTRL, 32'h0);
      pol <= 1'b0;
      clk(2);
      chk(lock_drive, 32'h1, "lock drive low level");
      wait_st(4'h8);
      chk({ch_a, ch_b, rd[10:8]}, 32'h6, "lock timeout");
      $display("test run done");
      lock_req <= 1'b0;
      pol <= 1'b1;
      act <= '{1'b1, 1'b1, 16'h3C3C};
      rst();
      wait_st(4'h6);
      act <= '{1'b1, 1'b1, 16'hA5A5};
      rst();
      wait_st(4'h8);
      chk({29'h0, rd[10:8]}, 32'h5, "deact cause");
      bus(1'b0, atc_pkg::REG_CODE, 32'h0);
      chk(rd, 32'h00003C3C, "kept code");
      act <= '{1'b1, 1'b1, 16'h0F0F};
      rst();
      wait_st(4'h5);
      act <= '0;
      wait_st(4'h8);
      chk({29'h0, rd[10:8]}, 32'h3, "removed cause");
      $display("test replace done");
      act <= '{1'b1, 1'b1, 16'h5A5A};
      rst();
      wait_st(4'h6);
      wait_st(4'h8);
      chk({29'h0, rd[10:8]}, 32'h2, "confirm cause");
      bus(1'b0, atc_pkg::REG_CODE, 32'h0);
      chk(rd, 32'h00003C3C, "old code kept");
      act <= '{1'b1, 1'b1, 16'h1234};
      rst();
      bus(1'b1, atc_pkg::REG_CTRL, 32'h3);
      wait_st(4'h7);
      chk({ch_a, ch_b}, 32'h3, "universal on");
      lock_req <= 1'b1;
      bolt_ok <= 1'b1;
      clk(4);
      chk({30'h0, ind.lock}, {30'h0, atc_pkg::COL_GREEN}, "locked");
      clk(120);
      wait_st(4'h7);
      $display("test universal done");
      close_out();
   end
   // watchdog
   initial begin
      clk(60000);
      err_count++;
      $display("CHECK FAILED %0t watchdog", $time);
      close_out();
   end
endmodule
